/* acc_control.sv */
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "acc_params.svh"

module acc_control (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hwTrigger,
  input wire logic stopMode,
  output acc_pkg::acc_core_req_t coreReq,
  input wire logic coreDone,
  input wire logic [15:0] coreResult,
  input wire logic [15:0] coreCalPlus,
  input wire logic [15:0] coreCalMinus,
  output logic [1:0] referenceSelect,
  output logic hardwareAverageEnable,
  output logic [1:0] averageSelect,
  output logic dmaRequest
);

  acc_pkg::acc_state_t state_ff;
  acc_pkg::acc_core_req_t coreReq_ff;
  acc_pkg::acc_cmp_cfg_t cmpCfg;
  logic awReady_ff, wReady_ff, awHave_ff, wHave_ff, bValid_ff;
  logic [1:0] bResp_ff, rResp_ff;
  logic arReady_ff, rValid_ff;
  logic [31:0] rData_ff, rdMux;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic hwTrigSel_ff, cmpEn_ff, gtSel_ff, rangeEn_ff, dma_request_enable_ff;
  logic [1:0] reference_select_ff, avgSel_ff;
  logic calFail_ff, contEn_ff, avgEn_ff;
  logic [15:0] cv1_ff, cv2_ff, result_ff, calPlus_ff, calMinus_ff;
  logic complete_ff, dmaReq_ff;
  logic [1:0] trigSync_ff, stopSync_ff;
  logic trigPrev_ff;
  logic wrEn, wrLow, wrHigh, rdEn, rdMapped, wrMapped, resultRead;
  logic calStart, swStart, hwStart, abortCmd, doneConv, calDone, calFailSet, calFailClr;
  logic match;

  assign cmpCfg = '{enable: cmpEn_ff, greater: gtSel_ff, range: rangeEn_ff};

  acc_compare u_compare (
    .result(coreResult),
    .cv1(cv1_ff),
    .cv2(cv2_ff),
    .cfg(cmpCfg),
    .match(match)
  );

  // Pin synchronisers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigSync_ff <= 2'h0;
      stopSync_ff <= 2'h0;
      trigPrev_ff <= 1'b0;
    end else begin
      trigSync_ff <= {trigSync_ff[0], hwTrigger};
      stopSync_ff <= {stopSync_ff[0], stopMode};
      trigPrev_ff <= trigSync_ff[1];
    end
  end

  // Write channel
  assign wrEn = awHave_ff && wHave_ff && !bValid_ff;
  assign wrLow = wrEn && wStrb_ff[0];
  assign wrHigh = wrEn && wStrb_ff[1];
  assign wrMapped = (awAddr_ff[7:5] == 3'h0) && (awAddr_ff[1:0] == 2'h0);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awReady_ff <= 1'b0;
      wReady_ff <= 1'b0;
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff <= `ACC_RESP_OKAY;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0;
      wStrb_ff <= 4'h0;
    end else begin
      awReady_ff <= s_axi_awvalid && !awReady_ff && !awHave_ff && !bValid_ff;
      wReady_ff <= s_axi_wvalid && !wReady_ff && !wHave_ff && !bValid_ff;
      if (s_axi_awvalid && awReady_ff) begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wReady_ff) begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (wrEn) begin
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff <= wrMapped ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else if (bValid_ff && s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
    end
  end

  // Read channel
  assign rdEn = s_axi_arvalid && arReady_ff;
  assign rdMapped = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);
  assign resultRead = rdEn && (s_axi_araddr == `ACC_OFS_RESULT);

  always_comb begin
    rdMux = 32'h0;
    unique case (s_axi_araddr)
      `ACC_OFS_CMP_CTRL: begin
        rdMux[`ACC_B_ACTIVE] = (state_ff == acc_pkg::ACC_CONV);
        rdMux[`ACC_B_HWTRIG] = hwTrigSel_ff;
        rdMux[`ACC_B_CMPEN] = cmpEn_ff;
        rdMux[`ACC_B_GT] = gtSel_ff;
        rdMux[`ACC_B_RANGE] = rangeEn_ff;
        rdMux[`ACC_B_DMA_REQUEST_ENABLE] = dma_request_enable_ff;
        rdMux[`ACC_B_REF_HI:`ACC_B_REF_LO] = reference_select_ff;
      end
      `ACC_OFS_CAL_CTRL: begin
        // Bits 31:8 and 5:4 stay at zero
        rdMux[`ACC_B_CAL] = (state_ff == acc_pkg::ACC_CAL);
        rdMux[`ACC_B_CALIBRATION_FAILED_FLAG] = calFail_ff;
        rdMux[`ACC_B_CONT] = contEn_ff;
        rdMux[`ACC_B_HARDWARE_AVERAGE_ENABLE] = avgEn_ff;
        rdMux[`ACC_B_AVGS_HI:`ACC_B_AVGS_LO] = avgSel_ff;
      end
      `ACC_OFS_CV1: rdMux[15:0] = cv1_ff;
      `ACC_OFS_CV2: rdMux[15:0] = cv2_ff;
      `ACC_OFS_CONV: rdMux[`ACC_B_START] = complete_ff;
      `ACC_OFS_RESULT: rdMux[15:0] = result_ff;
      `ACC_OFS_CAL_PLUS: rdMux[15:0] = calPlus_ff;
      `ACC_OFS_CAL_MINUS: rdMux[15:0] = calMinus_ff;
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arReady_ff <= 1'b0;
      rValid_ff <= 1'b0;
      rData_ff <= 32'h0;
      rResp_ff <= `ACC_RESP_OKAY;
    end else begin
      arReady_ff <= s_axi_arvalid && !arReady_ff && !rValid_ff;
      if (rdEn) begin
        rValid_ff <= 1'b1;
        rData_ff <= rdMux;
        rResp_ff <= rdMapped ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end else if (rValid_ff && s_axi_rready) begin
        rValid_ff <= 1'b0;
      end
    end
  end

  // Control register writes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hwTrigSel_ff <= 1'b0;
      cmpEn_ff <= 1'b0;
      gtSel_ff <= 1'b0;
      rangeEn_ff <= 1'b0;
      dma_request_enable_ff <= 1'b0;
      reference_select_ff <= `ACC_RST_REF;
      contEn_ff <= 1'b0;
      avgEn_ff <= 1'b0;
      avgSel_ff <= `ACC_RST_AVGS;
      cv1_ff <= `ACC_RST_CV;
      cv2_ff <= `ACC_RST_CV;
    end else begin
      if (wrLow && awAddr_ff == `ACC_OFS_CMP_CTRL) begin
        hwTrigSel_ff <= wData_ff[`ACC_B_HWTRIG];
        cmpEn_ff <= wData_ff[`ACC_B_CMPEN];
        gtSel_ff <= wData_ff[`ACC_B_GT];
        rangeEn_ff <= wData_ff[`ACC_B_RANGE];
        dma_request_enable_ff <= wData_ff[`ACC_B_DMA_REQUEST_ENABLE];
        // Reserved codes leave the previous selection in place
        if (wData_ff[`ACC_B_REF_HI:`ACC_B_REF_LO] == `ACC_REF_DEFAULT ||
            wData_ff[`ACC_B_REF_HI:`ACC_B_REF_LO] == `ACC_REF_ALT) begin
          reference_select_ff <= wData_ff[`ACC_B_REF_HI:`ACC_B_REF_LO];
        end
      end
      if (wrLow && awAddr_ff == `ACC_OFS_CAL_CTRL) begin
        contEn_ff <= wData_ff[`ACC_B_CONT];
        avgEn_ff <= wData_ff[`ACC_B_HARDWARE_AVERAGE_ENABLE];
        avgSel_ff <= wData_ff[`ACC_B_AVGS_HI:`ACC_B_AVGS_LO];
      end
      if (awAddr_ff == `ACC_OFS_CV1) begin
        if (wrLow) cv1_ff[7:0] <= wData_ff[7:0];
        if (wrHigh) cv1_ff[15:8] <= wData_ff[15:8];
      end
      if (awAddr_ff == `ACC_OFS_CV2) begin
        if (wrLow) cv2_ff[7:0] <= wData_ff[7:0];
        if (wrHigh) cv2_ff[15:8] <= wData_ff[15:8];
      end
    end
  end

  // Sequencing events
  assign calStart = wrLow && awAddr_ff == `ACC_OFS_CAL_CTRL && wData_ff[`ACC_B_CAL] &&
                    state_ff != acc_pkg::ACC_CAL;
  assign swStart = wrLow && awAddr_ff == `ACC_OFS_CONV && wData_ff[`ACC_B_START] && !hwTrigSel_ff;
  assign hwStart = hwTrigSel_ff && trigSync_ff[1] && !trigPrev_ff;
  assign abortCmd = wrLow && awAddr_ff == `ACC_OFS_CONV && wData_ff[`ACC_B_ABORT];
  assign doneConv = coreDone && state_ff == acc_pkg::ACC_CONV && !calStart && !abortCmd;
  assign calDone = coreDone && state_ff == acc_pkg::ACC_CAL;
  assign calFailSet = state_ff == acc_pkg::ACC_CAL &&
                      (hwTrigSel_ff || wrEn || stopSync_ff[1]);
  assign calFailClr = wrLow && awAddr_ff == `ACC_OFS_CAL_CTRL && wData_ff[`ACC_B_CALIBRATION_FAILED_FLAG];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= acc_pkg::ACC_IDLE;
      coreReq_ff <= '0;
    end else begin
      coreReq_ff <= '0;
      unique case (state_ff)
        acc_pkg::ACC_IDLE: begin
          if (calStart) begin
            coreReq_ff.calReq <= 1'b1;
            state_ff <= acc_pkg::ACC_CAL;
          end else if (swStart || hwStart) begin
            coreReq_ff.start <= 1'b1;
            state_ff <= acc_pkg::ACC_CONV;
          end
        end
        acc_pkg::ACC_CONV: begin
          if (calStart) begin
            coreReq_ff.abort <= 1'b1;
            coreReq_ff.calReq <= 1'b1;
            state_ff <= acc_pkg::ACC_CAL;
          end else if (abortCmd) begin
            coreReq_ff.abort <= 1'b1;
            state_ff <= acc_pkg::ACC_IDLE;
          end else if (doneConv) begin
            if (contEn_ff) begin
              coreReq_ff.start <= 1'b1;
            end else begin
              state_ff <= acc_pkg::ACC_IDLE;
            end
          end
        end
        acc_pkg::ACC_CAL: begin
          if (calDone) state_ff <= acc_pkg::ACC_IDLE;
        end
        default: state_ff <= acc_pkg::ACC_IDLE;
      endcase
    end
  end

  // Calibration flag and values
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      calFail_ff <= 1'b0;
      calPlus_ff <= 16'h0000;
      calMinus_ff <= 16'h0000;
    end else begin
      if (calFailSet) calFail_ff <= 1'b1;
      else if (calFailClr) calFail_ff <= 1'b0;
      if (calDone) begin
        calPlus_ff <= coreCalPlus;
        calMinus_ff <= coreCalMinus;
      end
    end
  end

  // Result capture, complete flag and DMA request
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_ff <= 16'h0000;
      complete_ff <= 1'b0;
      dmaReq_ff <= 1'b0;
    end else begin
      if (doneConv && match) begin
        result_ff <= coreResult;
        complete_ff <= 1'b1;
      end else if (resultRead) begin
        complete_ff <= 1'b0;
      end
      dmaReq_ff <= dma_request_enable_ff && complete_ff;
    end
  end

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
  assign coreReq = coreReq_ff;
  assign referenceSelect = reference_select_ff;
  assign hardwareAverageEnable = avgEn_ff;
  assign averageSelect = avgSel_ff;
  assign dmaRequest = dmaReq_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_below_match;
    doneConv && cmpEn_ff && !gtSel_ff && !rangeEn_ff && coreResult < cv1_ff |=> complete_ff;
  endproperty
  a_below_match: assert property (p_below_match) else $error("below threshold not flagged");

  property p_above_reject;
    doneConv && cmpEn_ff && gtSel_ff && !rangeEn_ff && coreResult < cv1_ff && !complete_ff
      |=> !complete_ff;
  endproperty
  a_above_reject: assert property (p_above_reject) else $error("below threshold flagged");

  property p_range_inside_incl;
    doneConv && cmpEn_ff && gtSel_ff && rangeEn_ff && cv1_ff <= cv2_ff &&
      coreResult == cv2_ff |=> complete_ff && result_ff == $past(coreResult);
  endproperty
  a_range_inside_incl: assert property (p_range_inside_incl) else $error("inclusive bound missed");

  property p_cmp_off;
    doneConv && !cmpEn_ff |=> complete_ff;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("result dropped with compare off");

  property p_dma;
    complete_ff |=> dmaReq_ff == $past(dma_request_enable_ff);
  endproperty
  a_dma: assert property (p_dma) else $error("dma request wrong");

  property p_dma_hold;
    dmaReq_ff && dma_request_enable_ff && complete_ff |=> dmaReq_ff;
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("dma request dropped early");

  property p_cal_abort;
    calStart && state_ff == acc_pkg::ACC_CONV
      |=> coreReq_ff.abort && coreReq_ff.calReq && state_ff == acc_pkg::ACC_CAL;
  endproperty
  a_cal_abort: assert property (p_cal_abort) else $error("calibration did not abort");

  property p_cal_end;
    calDone |=> state_ff == acc_pkg::ACC_IDLE && calPlus_ff == $past(coreCalPlus);
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("calibration end wrong");

  property p_cal_write_fail;
    state_ff == acc_pkg::ACC_CAL && wrEn |=> calFail_ff;
  endproperty
  a_cal_write_fail: assert property (p_cal_write_fail) else $error("write did not fail cal");

  property p_calibration_failed_flag_clear;
    calFail_ff && calFailClr && !calFailSet |=> !calFail_ff;
  endproperty
  a_calibration_failed_flag_clear: assert property (p_calibration_failed_flag_clear) else $error("failed flag not cleared");

  property p_single;
    doneConv && !contEn_ff |=> state_ff == acc_pkg::ACC_IDLE && !coreReq_ff.start;
  endproperty
  a_single: assert property (p_single) else $error("single mode restarted");

  property p_continuous;
    doneConv && contEn_ff |=> coreReq_ff.start && state_ff == acc_pkg::ACC_CONV;
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous did not restart");

  c_cal_pass: cover property (calDone && !calFailSet && !calFail_ff);
  c_cal_fail: cover property (calDone && calFail_ff);
  c_dma: cover property ($rose(dmaReq_ff));
  c_restart: cover property (doneConv && contEn_ff);

endmodule

/* acc_params.svh */
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register byte offsets
`define ACC_OFS_CMP_CTRL 8'h00
`define ACC_OFS_CAL_CTRL 8'h04
`define ACC_OFS_CV1 8'h08
`define ACC_OFS_CV2 8'h0c
`define ACC_OFS_CONV 8'h10
`define ACC_OFS_RESULT 8'h14
`define ACC_OFS_CAL_PLUS 8'h18
`define ACC_OFS_CAL_MINUS 8'h1c

// compare_dma_reference_control fields
`define ACC_B_ACTIVE 7
`define ACC_B_HWTRIG 6
`define ACC_B_CMPEN 5
`define ACC_B_GT 4
`define ACC_B_RANGE 3
`define ACC_B_DMA_REQUEST_ENABLE 2
`define ACC_B_REF_HI 1
`define ACC_B_REF_LO 0

// calibration_continuous_control fields
`define ACC_B_CAL 7
`define ACC_B_CALIBRATION_FAILED_FLAG 6
`define ACC_B_CONT 3
`define ACC_B_HARDWARE_AVERAGE_ENABLE 2
`define ACC_B_AVGS_HI 1
`define ACC_B_AVGS_LO 0

// Conversion command register fields
`define ACC_B_START 0
`define ACC_B_ABORT 1

// Reference select codes
`define ACC_REF_DEFAULT 2'h0
`define ACC_REF_ALT 2'h1

// Reset values
`define ACC_RST_REF 2'h0
`define ACC_RST_AVGS 2'h0
`define ACC_RST_CV 16'h0000

// Bus response codes
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

/* acc_pkg.sv */
package acc_pkg;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_CONV = 2'b01,
    ACC_CAL = 2'b10
  } acc_state_t;

  typedef struct packed {
    logic enable;
    logic greater;
    logic range;
  } acc_cmp_cfg_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic calReq;
  } acc_core_req_t;

endpackage

/* acc_compare.sv */
`timescale 1ns/1ps
module acc_compare (
  input wire logic [15:0] result,
  input wire logic [15:0] cv1,
  input wire logic [15:0] cv2,
  input wire acc_pkg::acc_cmp_cfg_t cfg,
  output logic match
);

  logic lowFirst;

  always_comb begin
    lowFirst = (cv1 <= cv2);
    if (!cfg.enable) begin
      match = 1'b1;
    end else if (!cfg.range) begin
      match = cfg.greater ? (result >= cv1) : (result < cv1);
    end else if (!cfg.greater) begin
      // Exclusive bounds; order of the two values picks outside or inside
      match = lowFirst ? (result < cv1 || result > cv2) : (result < cv1 && result > cv2);
    end else begin
      // Inclusive bounds
      match = lowFirst ? (result >= cv1 && result <= cv2) : (result >= cv1 || result <= cv2);
    end
  end

endmodule

/* acc_core_model.sv */
`timescale 1ns/1ps
module acc_core_model #(
  parameter logic [15:0] CAL_PLUS = 16'h1234,
  parameter logic [15:0] CAL_MINUS = 16'h0567
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire acc_pkg::acc_core_req_t coreReq,
  input wire logic [15:0] resultIn,
  input wire logic [7:0] latency,
  output logic coreDone,
  output logic [15:0] coreResult,
  output logic [15:0] coreCalPlus,
  output logic [15:0] coreCalMinus
);
  logic busy_ff;
  logic [7:0] cnt_ff;
  logic [15:0] last_ff;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      coreDone <= 1'b0;
      last_ff <= 16'h0000;
    end else begin
      coreDone <= 1'b0;
      if (coreReq.calReq) begin
        busy_ff <= 1'b1;
        cnt_ff <= latency;
      end else if (coreReq.start) begin
        busy_ff <= 1'b1;
        cnt_ff <= latency;
      end else if (coreReq.abort) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        if (cnt_ff == 8'h00) begin
          busy_ff <= 1'b0;
          coreDone <= 1'b1;
          last_ff <= resultIn;
        end else begin
          cnt_ff <= cnt_ff - 8'h01;
        end
      end
    end
  end
  // Values are only valid with the done pulse; otherwise show inverted garbage
  assign coreResult = coreDone ? resultIn : ~last_ff;
  assign coreCalPlus = coreDone ? CAL_PLUS : ~CAL_PLUS;
  assign coreCalMinus = coreDone ? CAL_MINUS : ~CAL_MINUS;
endmodule

/* test_adc_compare_calibration_control.sv */
`timescale 1ns/1ps
module test_adc_compare_calibration_control;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic hwTrigger = 1'b0, stopMode = 1'b0;
  logic [15:0] resultIn = 16'h0000;
  logic [7:0] latency = 8'h06;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, referenceSelect, averageSelect, resp;
  logic [31:0] s_axi_rdata, rd;
  acc_pkg::acc_core_req_t coreReq;
  logic coreDone, hardwareAverageEnable, dmaRequest;
  logic [15:0] coreResult, coreCalPlus, coreCalMinus;
  int errTotal = 0, checkCount = 0, startSeen = 0, abortSeen = 0, s;

  acc_control acc_control_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .hwTrigger(hwTrigger),
    .stopMode(stopMode), .coreReq(coreReq), .coreDone(coreDone), .coreResult(coreResult),
    .coreCalPlus(coreCalPlus), .coreCalMinus(coreCalMinus), .referenceSelect(referenceSelect),
    .hardwareAverageEnable(hardwareAverageEnable), .averageSelect(averageSelect),
    .dmaRequest(dmaRequest));
  acc_core_model acc_core_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .coreReq(coreReq),
    .resultIn(resultIn), .latency(latency), .coreDone(coreDone), .coreResult(coreResult),
    .coreCalPlus(coreCalPlus), .coreCalMinus(coreCalMinus));

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (coreReq.start === 1'b1) startSeen++;
    if (coreReq.abort === 1'b1) abortSeen++;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (exp !== got) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits for the answer however long it takes; only the watchdog ends a hang
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    check("write response", (a < 8'h20) ? 32'h0 : 32'h2, {30'h0, resp});
  endtask

  task automatic axiRead(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    check("read response", (a < 8'h20) ? 32'h0 : 32'h2, {30'h0, resp});
  endtask

  task automatic waitDone();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (coreDone !== 1'b1 && n < 600);
    repeat (4) @(posedge ref_clk);
    check("core done", 1'b1, n < 600);
  endtask

  task automatic calWait();
    int n;
    n = 0;
    do begin
      axiRead(8'h04);
      n++;
    end while (rd[7] !== 1'b0 && n < 100);
    check("cal bit clears", 1'b0, rd[7]);
  endtask

  // cfg is {enable, greater, range, dma}
  task automatic runConv(input logic [3:0] cfg, input logic [15:0] c1, input logic [15:0] c2,
                         input logic [15:0] r, input logic e);
    axiWrite(8'h08, {16'h0000, c1});
    axiWrite(8'h0c, {16'h0000, c2});
    axiWrite(8'h00, {26'h0, cfg, 2'h0});
    resultIn <= r;
    s = startSeen;
    axiWrite(8'h10, 32'h1);
    waitDone();
    check("starts per initiation", 32'h1, 32'(startSeen - s));
    axiRead(8'h10);
    check("complete flag", {31'h0, e}, rd);
    check("dma request", e & cfg[0], dmaRequest);
    axiRead(8'h14);
    if (e) check("result", {16'h0000, r}, rd);
    repeat (2) @(posedge ref_clk);
    check("dma released", 1'b0, dmaRequest);
  endtask

  task automatic calFail(input int m);
    if (m == 2) axiWrite(8'h00, 32'h40);
    axiWrite(8'h04, 32'h80);
    if (m == 0) axiWrite(8'h08, 32'h0);
    if (m == 1) begin
      stopMode <= 1'b1;
      repeat (6) @(posedge ref_clk);
      stopMode <= 1'b0;
    end
    calWait();
    check("cal failed", 32'h40, rd);
    axiWrite(8'h04, 32'h0);
    axiRead(8'h04);
    check("failed kept", 32'h40, rd);
    axiWrite(8'h04, 32'h40);
    axiRead(8'h04);
    check("failed cleared", 32'h0, rd);
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    errTotal++;
    $display("ERROR watchdog expected finish seen timeout");
    closeOut();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    axiRead(8'h00);
    check("control reset", 32'h0, rd);
    axiRead(8'h04);
    check("cal control reset", 32'h0, rd);
    axiWrite(8'h04, 32'hffffff3f);
    axiRead(8'h04);
    check("reserved bits", 32'h0000000f, rd);
    check("average outputs", 3'h7, {hardwareAverageEnable, averageSelect});
    axiWrite(8'h04, 32'h0);
    for (int i = 0; i < 4; i++) begin
      axiWrite(8'h00, 32'(i));
      check("reference select", (i < 2) ? 32'(i) : 32'h1, referenceSelect);
    end
    axiWrite(8'h40, 32'h1);
    check("unmapped write", 2'h2, resp);
    axiRead(8'h40);
    check("unmapped read", 32'h0, rd);
    $display("test registers done");
    runConv(4'h0, 16'h0000, 16'h0000, 16'h0123, 1'b0 | 1'b1);
    runConv(4'h6, 16'h0064, 16'h00c8, 16'h0000, 1'b1);
    runConv(4'h9, 16'h0064, 16'h0000, 16'h0063, 1'b1);
    runConv(4'h9, 16'h0064, 16'h0000, 16'h0064, 1'b0);
    runConv(4'hd, 16'h0064, 16'h0000, 16'h0064, 1'b1);
    runConv(4'hc, 16'h0064, 16'h0000, 16'h0063, 1'b0);
    runConv(4'hc, 16'h0064, 16'h0032, 16'h003c, 1'b0);
    runConv(4'hb, 16'h0064, 16'h00c8, 16'h0064, 1'b0);
    runConv(4'hb, 16'h0064, 16'h00c8, 16'h0032, 1'b1);
    runConv(4'hf, 16'h0064, 16'h00c8, 16'h00c8, 1'b1);
    runConv(4'hf, 16'h0064, 16'h00c8, 16'h00c9, 1'b0);
    runConv(4'ha, 16'h00c8, 16'h0064, 16'h0096, 1'b1);
    runConv(4'he, 16'h00c8, 16'h0064, 16'h0064, 1'b1);
    runConv(4'h8, 16'h0064, 16'h0000, 16'h0010, 1'b1);
    $display("test compare done");
    axiWrite(8'h00, 32'h0);
    axiWrite(8'h04, 32'h08);
    s = startSeen;
    axiWrite(8'h10, 32'h1);
    repeat (60) @(posedge ref_clk);
    check("continuous restarts", 1'b1, (startSeen - s) >= 4);
    s = abortSeen;
    axiWrite(8'h10, 32'h2);
    @(posedge ref_clk);
    check("abort sent", 32'h1, 32'(abortSeen - s));
    axiWrite(8'h04, 32'h0);
    axiRead(8'h00);
    check("active after abort", 1'b0, rd[7]);
    axiRead(8'h14);
    s = startSeen;
    repeat (30) @(posedge ref_clk);
    check("no restart", 32'h0, 32'(startSeen - s));
    $display("test continuous done");
    latency <= 8'h32;
    axiWrite(8'h10, 32'h1);
    axiRead(8'h00);
    check("active running", 1'b1, rd[7]);
    axiWrite(8'h04, 32'h80);
    axiRead(8'h04);
    check("cal running", 32'h80, rd);
    axiRead(8'h00);
    check("conversion aborted", 1'b0, rd[7]);
    calWait();
    check("cal passed", 32'h0, rd);
    axiRead(8'h18);
    check("plus values", 32'h00001234, rd);
    axiRead(8'h1c);
    check("minus values", 32'h00000567, rd);
    axiRead(8'h10);
    check("no stale complete", 32'h0, rd);
    latency <= 8'h1e;
    for (int m = 0; m < 3; m++) calFail(m);
    s = startSeen;
    latency <= 8'h06;
    hwTrigger <= 1'b1;
    repeat (8) @(posedge ref_clk);
    hwTrigger <= 1'b0;
    check("hardware start", 32'h1, 32'(startSeen - s));
    waitDone();
    axiRead(8'h14);
    $display("test calibration done");
    closeOut();
  end
endmodule
